// file: hw/async_serial_uart_core.sv
// Function
// - One clock, rising edge, serial and modem pins synchronised.
// - Control registers change only through host port.
// - Baud divider divides clock by divisor.
// - Sixteen sub-ticks make one bit clock.
// - Reset loads divisor with one.
// - Word length five to eight bits.
// - Even, odd or no parity.
// - One, one and half, two stops.
// - Flag overrun, framing, parity, break.
// - Received character goes to holding register.
// - False start bit returns to idle.
// - Transmit frames held character with stops.
// - Four separately enabled interrupt sources.
// - One interrupt line, priority code readable.
// - Interrupt on empty, data, error, modem.
// - Active-low modem handshake lines.
// - Loopback routes outputs back to inputs.
// - Split buses with drive disable output.
// - Single read, write, chip select.
// - Address used directly, no strobe.
// - Read data holds until next read.
module async_serial_uart_core (
  input wire logic mclk,
  input wire logic arst_n,
  input wire uart_pkg::host_req_t host_req,
  output logic [7:0] rdata,
  output logic bus_drive_disable,
  output logic irq,
  input wire logic serial_in,
  output logic serial_out,
  output logic baud_out,
  input wire uart_pkg::modem_in_t modem_in,
  output uart_pkg::modem_out_t modem_out
);
  import uart_pkg::*;
  `include "uart_defines.svh"

  // ****************************************************************
  // State and shared strobes.
  // ****************************************************************

  // The whole state of the core and its next value.
  core_state_t s_r;
  core_state_t s_nxt;
  // Sixteen-times enable and bit-rate strobe from the divider.
  logic tick16;
  logic bit_tick;
  // Host decode.
  logic wr_en;
  logic rd_en;
  logic dlab;
  // Modem status after the loopback mux, active high.
  logic [3:0] m_now;
  // Receive line after the loopback mux.
  logic rx_line;
  // Interrupt source requests and the resolved code.
  logic int_line;
  logic int_rx;
  logic int_tx;
  logic int_modem;
  logic [3:0] iid;
  // Last data bit index, transmit end-of-bit limit and flags.
  logic [2:0] wlast;
  logic [4:0] tx_lim;
  logic tx_end;
  logic rx_end;
  logic temt;
  logic [7:0] rx_word;
  logic rx_pexp;
  logic [7:0] rd_val;

  // ****************************************************************
  // Baud rate generator.
  // ****************************************************************

  // A zero divisor needs no care from the host; the divider runs it as one.
  baud_gen u_baud (
    .mclk(mclk),
    .arst_n(arst_n),
    .divisor(s_r.div),
    .tick16(tick16),
    .bit_tick(bit_tick),
    .baud_out(baud_out)
  );

  // ****************************************************************
  // Outputs and decode, all from flops or plain gates.
  // ****************************************************************

  // Chip select qualifies both strobes; the address is used as it stands.
  assign wr_en = host_req.cs & host_req.wr;
  assign rd_en = host_req.cs & host_req.rd;
  assign dlab = s_r.lcr[`LC_DIV_ACC];
  // Read data stays until another read replaces it.
  assign rdata = s_r.rdata;
  // External drivers may drive only in the cycle that shows read data.
  assign bus_drive_disable = ~s_r.rd_valid;
  // Loopback parks the line high; break forces it low.
  assign serial_out = ~s_r.lcr[`LC_BREAK] & (s_r.mcr[`MC_LOOP] | s_r.txd);
  // Handshake outputs are active low and go inactive in loopback.
  assign modem_out.request_to_send_out = s_r.mcr[`MC_LOOP] | ~s_r.mcr[`MC_RTS];
  assign modem_out.terminal_ready_out = s_r.mcr[`MC_LOOP] | ~s_r.mcr[`MC_DTR];

  // Loopback feeds control outputs back as status: cts, dsr, ri, dcd.
  assign m_now = s_r.mcr[`MC_LOOP] ? {s_r.mcr[`MC_AUX2], s_r.mcr[`MC_AUX1],
                                      s_r.mcr[`MC_DTR], s_r.mcr[`MC_RTS]}
                                   : s_r.m_s2;
  assign rx_line = s_r.mcr[`MC_LOOP] ? s_r.txd : s_r.rx_s[1];

  // Word length code zero means five bits, so the last index is four.
  assign wlast = `WLEN_BASE + {1'b0, s_r.lcr[1:0]};
  // One and a half stops apply only to five-bit words.
  always_comb begin
    tx_lim = `LIM_BIT;
    if (s_r.tx_st == TX_STOP && s_r.lcr[`LC_STOP]) begin
      tx_lim = (s_r.lcr[1:0] == 2'h0) ? `LIM_STOP15 : `LIM_STOP2;
    end
  end
  assign tx_end = tick16 && (s_r.tx_sub == tx_lim);
  assign rx_end = tick16 && (s_r.rx_sub == `SUB_LAST);
  assign temt = ~s_r.thr_full & (s_r.tx_st == TX_IDLE);
  // Received bits enter at the top, so short words need aligning down.
  assign rx_word = s_r.rsr >> (2'h3 - s_r.lcr[1:0]);
  // Stick parity forces the bit; else even takes the plain XOR.
  assign rx_pexp = s_r.lcr[`LC_PAR_STICK] ? ~s_r.lcr[`LC_PAR_EVEN]
                 : (s_r.lcr[`LC_PAR_EVEN] ? ^rx_word : ~^rx_word);

  // ****************************************************************
  // Interrupt priority.
  // ****************************************************************

  // Each source has its own enable bit.
  assign int_line = s_r.ier[`IE_LINE] & (s_r.oe | s_r.pe | s_r.fe | s_r.bi);
  assign int_rx = s_r.ier[`IE_RX] & s_r.dr;
  assign int_tx = s_r.ier[`IE_TX] & s_r.thre_int;
  assign int_modem = s_r.ier[`IE_MODEM] & (|s_r.delta);

  // Line errors outrank data, data outranks empty, empty outranks modem.
  always_comb begin
    if (int_line) begin
      iid = `IID_LINE;
    end else if (int_rx) begin
      iid = `IID_RX;
    end else if (int_tx) begin
      iid = `IID_TX;
    end else if (int_modem) begin
      iid = `IID_MODEM;
    end else begin
      iid = `IID_NONE;
    end
  end
  assign irq = ~iid[0];

  // ****************************************************************
  // Read multiplexer.
  // ****************************************************************

  // The divisor latch bit swaps the first two offsets to the divisor.
  always_comb begin
    unique case (host_req.addr)
      `OFS_HOLD: rd_val = dlab ? s_r.div[7:0] : s_r.rbr;
      `OFS_INT_EN: rd_val = dlab ? s_r.div[15:8] : {4'h0, s_r.ier};
      `OFS_INT_ID: rd_val = {4'h0, iid};
      `OFS_LINE_CTRL: rd_val = s_r.lcr;
      `OFS_MODEM_CTRL: rd_val = {3'h0, s_r.mcr};
      `OFS_LINE_STAT: rd_val = {1'b0, temt, ~s_r.thr_full, s_r.bi,
                                s_r.fe, s_r.pe, s_r.oe, s_r.dr};
      `OFS_MODEM_STAT: rd_val = {m_now, s_r.delta};
      `OFS_SCRATCH: rd_val = s_r.scr;
    endcase
  end

  // ****************************************************************
  // Next-state logic. Read clears come first so later sets win.
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;

    // Two flops on every serial and modem pin before any logic looks at it.
    s_nxt.rx_s = {s_r.rx_s[0], serial_in};
    s_nxt.m_s1 = ~{modem_in.carrier_detect_in, modem_in.incoming_call_signal,
                   modem_in.data_set_ready_in, modem_in.clear_to_send_in};
    s_nxt.m_s2 = s_r.m_s1;
    s_nxt.m_prev = m_now;

    // Host read and its side effects.
    s_nxt.rd_valid = rd_en;
    if (rd_en) begin
      s_nxt.rdata = rd_val;
      unique case (host_req.addr)
        `OFS_HOLD: begin
          if (!dlab) begin
            s_nxt.dr = 1'b0;
          end
        end
        `OFS_INT_ID: begin
          // Reading the code clears an empty interrupt it names.
          if (iid == `IID_TX) begin
            s_nxt.thre_int = 1'b0;
          end
        end
        `OFS_LINE_STAT: begin
          s_nxt.oe = 1'b0;
          s_nxt.pe = 1'b0;
          s_nxt.fe = 1'b0;
          s_nxt.bi = 1'b0;
        end
        `OFS_MODEM_STAT: s_nxt.delta = 4'h0;
        default: begin
        end
      endcase
    end

    // Modem deltas; ring reports only its trailing edge.
    s_nxt.delta = s_nxt.delta | {m_now[3] ^ s_r.m_prev[3], ~m_now[2] & s_r.m_prev[2],
                                 m_now[1:0] ^ s_r.m_prev[1:0]};

    // Transmitter. Starts wait for the bit clock to stay in step.
    unique case (s_r.tx_st)
      TX_IDLE: begin
        if (bit_tick && s_r.thr_full) begin
          s_nxt.tsr = s_r.thr;
          s_nxt.thr_full = 1'b0;
          s_nxt.thre_int = 1'b1;
          s_nxt.tx_par = ^(s_r.thr & ~(8'hfe << wlast));
          s_nxt.tx_st = TX_START;
          s_nxt.txd = 1'b0;
          s_nxt.tx_sub = 5'h00;
        end
      end
      TX_START: begin
        if (tx_end) begin
          s_nxt.tx_st = TX_DATA;
          s_nxt.txd = s_r.tsr[0];
          s_nxt.tx_cnt = 3'h0;
        end
      end
      TX_DATA: begin
        if (tx_end) begin
          if (s_r.tx_cnt != wlast) begin
            s_nxt.tsr = s_r.tsr >> 1;
            s_nxt.txd = s_r.tsr[1];
            s_nxt.tx_cnt = s_r.tx_cnt + 3'h1;
          end else if (s_r.lcr[`LC_PAR_EN]) begin
            s_nxt.tx_st = TX_PAR;
            s_nxt.txd = s_r.lcr[`LC_PAR_STICK] ? ~s_r.lcr[`LC_PAR_EVEN]
                      : (s_r.lcr[`LC_PAR_EVEN] ? s_r.tx_par : ~s_r.tx_par);
          end else begin
            s_nxt.tx_st = TX_STOP;
            s_nxt.txd = 1'b1;
          end
        end
      end
      TX_PAR: begin
        if (tx_end) begin
          s_nxt.tx_st = TX_STOP;
          s_nxt.txd = 1'b1;
        end
      end
      TX_STOP: begin
        if (tx_end) begin
          s_nxt.tx_st = TX_IDLE;
        end
      end
    endcase
    if (s_r.tx_st != TX_IDLE && tick16) begin
      // The counter wraps to zero at each bit end: sixteen ticks, or 24 or 32 for long stops.
      s_nxt.tx_sub = tx_end ? 5'h00 : s_r.tx_sub + 5'h01;
    end

    // Receiver, timed in sixteenths of a bit.
    unique case (s_r.rx_st)
      RX_IDLE: begin
        if (!rx_line) begin
          s_nxt.rx_st = RX_START;
          s_nxt.rx_sub = 4'h0;
        end
      end
      RX_START: begin
        if (tick16) begin
          s_nxt.rx_sub = s_r.rx_sub + 4'h1;
          if (s_r.rx_sub == `SUB_MID) begin
            if (rx_line) begin
              s_nxt.rx_st = RX_IDLE;
            end else begin
              s_nxt.rx_st = RX_DATA;
              s_nxt.rx_sub = 4'h0;
              s_nxt.rx_cnt = 3'h0;
            end
          end
        end
      end
      RX_DATA: begin
        if (tick16) begin
          s_nxt.rx_sub = s_r.rx_sub + 4'h1;
        end
        if (rx_end) begin
          // Sixteen ticks after mid-start is mid-bit.
          s_nxt.rsr = {rx_line, s_r.rsr[7:1]};
          s_nxt.rx_cnt = s_r.rx_cnt + 3'h1;
          if (s_r.rx_cnt == wlast) begin
            s_nxt.rx_st = s_r.lcr[`LC_PAR_EN] ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (tick16) begin
          s_nxt.rx_sub = s_r.rx_sub + 4'h1;
        end
        if (rx_end) begin
          s_nxt.rx_pbit = rx_line;
          s_nxt.rx_st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (tick16) begin
          s_nxt.rx_sub = s_r.rx_sub + 4'h1;
        end
        if (rx_end) begin
          // Only the first stop bit is checked, as a receiver should.
          s_nxt.rbr = rx_word;
          s_nxt.dr = 1'b1;
          s_nxt.oe = s_nxt.oe | (s_r.dr & ~(rd_en && !dlab &&
                     host_req.addr == `OFS_HOLD));
          s_nxt.pe = s_nxt.pe | (s_r.lcr[`LC_PAR_EN] & (s_r.rx_pbit ^ rx_pexp));
          s_nxt.fe = s_nxt.fe | ~rx_line;
          s_nxt.bi = s_nxt.bi | (~rx_line & (rx_word == 8'h00) &
                     ~(s_r.lcr[`LC_PAR_EN] & s_r.rx_pbit));
          s_nxt.rx_st = RX_IDLE;
        end
      end
    endcase

    // Host writes; the only path into the control, divisor and scratch registers.
    if (wr_en) begin
      unique case (host_req.addr)
        `OFS_HOLD: begin
          if (dlab) begin
            s_nxt.div[7:0] = host_req.wdata;
          end else begin
            // A write in the load cycle refills the holding register.
            s_nxt.thr = host_req.wdata;
            s_nxt.thr_full = 1'b1;
            s_nxt.thre_int = 1'b0;
          end
        end
        `OFS_INT_EN: begin
          if (dlab) begin
            s_nxt.div[15:8] = host_req.wdata;
          end else begin
            s_nxt.ier = host_req.wdata[3:0];
            // Enabling the empty source while empty raises it at once.
            if (host_req.wdata[`IE_TX] && !s_r.ier[`IE_TX] && !s_r.thr_full) begin
              s_nxt.thre_int = 1'b1;
            end
          end
        end
        `OFS_LINE_CTRL: s_nxt.lcr = host_req.wdata;
        `OFS_MODEM_CTRL: s_nxt.mcr = host_req.wdata[4:0];
        `OFS_SCRATCH: s_nxt.scr = host_req.wdata;
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // State register, rising edge of the single clock.
  // ****************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.div <= `DIV_RESET;
      s_r.rx_s <= '1;
      s_r.txd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// file: hw/uart_defines.svh
`ifndef UART_DEFINES_SVH
`define UART_DEFINES_SVH

// ****************************************************************
// Register offsets on the three-bit host address.
// ****************************************************************
`define OFS_HOLD 3'h0
`define OFS_INT_EN 3'h1
`define OFS_INT_ID 3'h2
`define OFS_LINE_CTRL 3'h3
`define OFS_MODEM_CTRL 3'h4
`define OFS_LINE_STAT 3'h5
`define OFS_MODEM_STAT 3'h6
`define OFS_SCRATCH 3'h7

// ****************************************************************
// Reset values.
// ****************************************************************
`define DIV_RESET 16'h0001
`define CNT_RESET 16'h0001

// ****************************************************************
// Line control fields; bits 1:0 hold the word length minus five.
// ****************************************************************
`define LC_STOP 2
`define LC_PAR_EN 3
`define LC_PAR_EVEN 4
`define LC_PAR_STICK 5
`define LC_BREAK 6
`define LC_DIV_ACC 7

// ****************************************************************
// Modem control fields and interrupt enable fields.
// ****************************************************************
`define MC_DTR 0
`define MC_RTS 1
`define MC_AUX1 2
`define MC_AUX2 3
`define MC_LOOP 4
`define IE_RX 0
`define IE_TX 1
`define IE_LINE 2
`define IE_MODEM 3

// ****************************************************************
// Interrupt identification codes, highest priority first.
// ****************************************************************
`define IID_LINE 4'h6
`define IID_RX 4'h4
`define IID_TX 4'h2
`define IID_MODEM 4'h0
`define IID_NONE 4'h1

// ****************************************************************
// Sixteenth-of-a-bit timing.
// ****************************************************************
`define SUB_MID 4'h7
`define SUB_LAST 4'hf
`define PHASE_LAST 4'hf
`define LIM_BIT 5'h0f
`define LIM_STOP15 5'h17
`define LIM_STOP2 5'h1f
`define WLEN_BASE 3'h4

`endif

// file: hw/uart_pkg.sv
package uart_pkg;

  // ****************************************************************
  // Host request and modem line carriers.
  // ****************************************************************
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  // Modem inputs as they arrive on the pins, all active low.
  typedef struct packed {
    logic clear_to_send_in;
    logic data_set_ready_in;
    logic incoming_call_signal;
    logic carrier_detect_in;
  } modem_in_t;

  // Modem outputs, active low.
  typedef struct packed {
    logic request_to_send_out;
    logic terminal_ready_out;
  } modem_out_t;

  // ****************************************************************
  // State machines and module state.
  // ****************************************************************
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [3:0] phase;
  } baud_state_t;

  typedef struct packed {
    logic [1:0] rx_s;
    logic [3:0] m_s1;
    logic [3:0] m_s2;
    logic [3:0] m_prev;
    logic [3:0] delta;
    logic [15:0] div;
    logic [7:0] lcr;
    logic [4:0] mcr;
    logic [3:0] ier;
    logic [7:0] scr;
    logic [7:0] rdata;
    logic rd_valid;
    logic [7:0] thr;
    logic thr_full;
    logic thre_int;
    logic [7:0] tsr;
    tx_state_t tx_st;
    logic [4:0] tx_sub;
    logic [2:0] tx_cnt;
    logic tx_par;
    logic txd;
    rx_state_t rx_st;
    logic [3:0] rx_sub;
    logic [2:0] rx_cnt;
    logic [7:0] rsr;
    logic rx_pbit;
    logic [7:0] rbr;
    logic dr;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
  } core_state_t;

endpackage

// file: hw/baud_gen.sv
module baud_gen (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [15:0] divisor,
  output logic tick16,
  output logic bit_tick,
  output logic baud_out
);
  import uart_pkg::*;
  `include "uart_defines.svh"

  // Current and next state of the divider chain.
  baud_state_t s_r;
  baud_state_t s_nxt;

  // A divisor of one gives a tick every clock; zero acts the same as one.
  assign tick16 = (s_r.cnt <= `CNT_RESET);
  // The bit strobe falls on the last of sixteen sub-ticks.
  assign bit_tick = tick16 && (s_r.phase == `PHASE_LAST);
  // Square bit-rate clock taken straight from the phase flop.
  assign baud_out = ~s_r.phase[3];

  // ****************************************************************
  // Programmable divider followed by the fixed divide by sixteen.
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    if (tick16) begin
      // Reload on the tick so that a new divisor acts at a clean edge.
      s_nxt.cnt = divisor;
      s_nxt.phase = s_r.phase + 4'h1;
    end else begin
      s_nxt.cnt = s_r.cnt - 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.cnt <= `CNT_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// file: tb/uart_chk.sv
module uart_chk import uart_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  input wire uart_pkg::host_req_t host_req,
  input wire logic [7:0] rdata,
  input wire logic bus_drive_disable,
  input wire logic serial_out,
  input wire uart_pkg::modem_out_t modem_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Host port and serial line checks, all on the one clock.
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // A read counts only with chip select beside it.
  sequence s_rd;
    host_req.cs && host_req.rd;
  endsequence
  // Any line level lasts a whole bit, so at least eight clocks.
  sequence s_lo;
    !serial_out [*8];
  endsequence
  sequence s_hi;
    serial_out [*8];
  endsequence
  property p_dis_rd;
    s_rd |=> !bus_drive_disable;
  endproperty
  a_dis_rd: assert property (p_dis_rd) else $error("drive disable high after read");
  property p_dis_hi;
    !(host_req.cs && host_req.rd) |=> bus_drive_disable;
  endproperty
  a_dis_hi: assert property (p_dis_hi) else $error("drive disable low without read");
  property p_hold;
    !(host_req.cs && host_req.rd) |=> $stable(rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_rd_cause;
    $changed(rdata) |-> $past(host_req.cs && host_req.rd);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read data changed unasked");
  property p_no_cs;
    (host_req.rd && !host_req.cs) |=> bus_drive_disable;
  endproperty
  a_no_cs: assert property (p_no_cs) else $error("read taken without select");
  property p_mdm;
    $changed(modem_out) |-> $past(host_req.cs && host_req.wr);
  endproperty
  a_mdm: assert property (p_mdm) else $error("modem outputs moved without write");
  property p_lo;
    $fell(serial_out) |-> s_lo;
  endproperty
  a_lo: assert property (p_lo) else $error("short low level on line");
  property p_hi;
    $rose(serial_out) |-> s_hi;
  endproperty
  a_hi: assert property (p_hi) else $error("short high level on line");
endmodule

bind async_serial_uart_core uart_chk chk_u (
  .mclk(mclk),
  .arst_n(arst_n),
  .host_req(host_req),
  .rdata(rdata),
  .bus_drive_disable(bus_drive_disable),
  .serial_out(serial_out),
  .modem_out(modem_out)
);

// file: tb/serial_peer.sv
// Far-end serial device: frames characters onto the line and decodes ours.
module serial_peer import uart_pkg::*; (
  input wire logic mclk,
  input wire logic line_rx,
  output logic line_tx,
  output uart_pkg::modem_in_t modem_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_clks = 16; // Clocks per bit; must follow the divisor.
  initial begin
    line_tx = 1'b1;
    modem_in = '1;
  end
  // Holds the line at one level for a number of clocks.
  task level(logic v, int n);
    line_tx <= v;
    repeat (n) @(posedge mclk);
  endtask
  task m_set(modem_in_t v);
    @(posedge mclk);
    modem_in <= v;
  endtask
  // Low start, eight data bits from the bottom, optional parity, one stop.
  task send(logic [7:0] d, logic pen, logic pb, logic stp);
    int i;
    @(posedge mclk);
    level(1'b0, bit_clks);
    for (i = 0; i < 8; i++) begin
      level(d[i], bit_clks);
    end
    if (pen) begin
      level(pb, bit_clks);
    end
    level(stp, bit_clks);
    level(1'b1, 2);
  endtask
  // Decodes one frame, sampling each bit in its middle.
  task recv(int n, logic pen, output logic [7:0] d, output logic p, output bit ok);
    int i;
    ok = 0;
    d = '0;
    p = 1'b0;
    for (i = 0; i < 4000 && line_rx !== 1'b0; i++) @(posedge mclk);
    repeat (bit_clks / 2) @(posedge mclk);
    if (line_rx !== 1'b0) begin
      return;
    end
    for (i = 0; i < n; i++) begin
      repeat (bit_clks) @(posedge mclk);
      d[i] = line_rx;
    end
    if (pen) begin
      repeat (bit_clks) @(posedge mclk);
      p = line_rx;
    end
    repeat (bit_clks) @(posedge mclk);
    ok = (line_rx === 1'b1);
  endtask
endmodule

// file: tb/async_serial_uart_core_tb.sv
`include "uart_defines.svh"
module async_serial_uart_core_tb import uart_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  host_req_t hreq = '0;
  logic serial_in, serial_out, baud_out, irq, bus_drive_disable;
  logic [7:0] rdata, q;
  modem_in_t m_in;
  modem_out_t modem_out;
  int mismatches = 0;
  int tests_run = 0;
  logic p;
  bit ok, lb_bad;
  logic [7:0] tab [4] = '{8'h04, 8'h39, 8'h1a, 8'h1f}; // Line control per pass.
  always #5 mclk = ~mclk;
  async_serial_uart_core dut_u (.mclk(mclk), .arst_n(arst_n), .host_req(hreq),
    .rdata(rdata), .bus_drive_disable(bus_drive_disable), .irq(irq),
    .serial_in(serial_in), .serial_out(serial_out), .baud_out(baud_out),
    .modem_in(m_in), .modem_out(modem_out));
  serial_peer peer_u (.mclk(mclk), .line_rx(serial_out), .line_tx(serial_in),
    .modem_in(m_in));
  // ****
  // Access, compare and closing tasks.
  // ****
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  task fail_if(bit b);
    if (b) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // One strobe cycle; read data is taken in the cycle that follows.
  task acc(logic c, logic r, logic [2:0] a, logic [7:0] d);
    @(posedge mclk);
    hreq <= '{c, r, !r, a, d};
    @(posedge mclk);
    hreq <= '0;
    #1;
    q = rdata;
  endtask
  task wr(logic [2:0] a, logic [7:0] d);
    acc(1'b1, 1'b0, a, d);
  endtask
  task rc(string n, logic [2:0] a, logic [7:0] m, logic [7:0] e);
    acc(1'b1, 1'b1, a, 8'h00);
    chk(n, e, q & m);
  endtask
  // Polls for received data while the outside line must stay idle.
  task wait_dr;
    int i;
    for (i = 0; i < 400; i++) begin
      acc(1'b1, 1'b1, `OFS_LINE_STAT, 8'h00);
      lb_bad |= (serial_out !== 1'b1);
      if (q[0] === 1'b1) break;
    end
    fail_if(i == 400);
  endtask
  task till(logic v, output int n);
    n = 0;
    while (baud_out !== v && n < 2000) begin
      tick(1);
      n++;
    end
    fail_if(n >= 2000);
  endtask
  // Bit clock period is the high time plus the low time.
  task per(logic [7:0] e);
    int a, b;
    till(1'b0, a);
    till(1'b1, a);
    till(1'b0, a);
    till(1'b1, b);
    chk("baud period", e, 8'(a + b));
  endtask
  task txc(logic [7:0] lc, logic [7:0] d);
    int n;
    logic [7:0] r, dm;
    n = lc[1:0] + 5;
    dm = d & ((8'h01 << n) - 8'h01);
    tick(32);
    wr(`OFS_LINE_CTRL, lc);
    wr(`OFS_HOLD, d);
    peer_u.recv(n, lc[3], r, p, ok);
    fail_if(!ok);
    chk("tx data", dm, r);
    if (lc[3]) begin
      chk("tx parity", {7'h0, lc[5] ? !lc[4] : ^dm ^ !lc[4]}, {7'h0, p});
    end
  endtask
  task rxs(logic [7:0] d, logic bad, logic stp);
    peer_u.send(d, 1'b1, ^d ^ bad, stp);
  endtask
  // ****
  // Main sequence.
  // ****
  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    tick(1);
    chk("rdata reset", 8'h00, rdata);
    chk("drive disable", 8'h01, {7'h0, bus_drive_disable});
    chk("modem out", 8'h03, {6'h0, modem_out});
    rc("line stat", `OFS_LINE_STAT, 8'hff, 8'h60);
    rc("int id", `OFS_INT_ID, 8'hff, 8'h01);
    wr(`OFS_LINE_CTRL, 8'h80);
    rc("div low", `OFS_HOLD, 8'hff, 8'h01);
    rc("div high", `OFS_INT_EN, 8'hff, 8'h00);
    wr(`OFS_LINE_CTRL, 8'h03);
    per(8'd16);
    $display("test reset done");
    wr(`OFS_SCRATCH, 8'h5a);
    acc(1'b0, 1'b0, `OFS_SCRATCH, 8'ha5);
    acc(1'b0, 1'b1, `OFS_SCRATCH, 8'h00);
    rc("scratch", `OFS_SCRATCH, 8'hff, 8'h5a);
    tick(5);
    chk("rdata hold", 8'h5a, rdata);
    wr(`OFS_INT_ID, 8'hff);
    rc("int id ro", `OFS_INT_ID, 8'hff, 8'h01);
    $display("test registers done");
    for (int i = 0; i < 4; i++) txc(tab[i], 8'h5b ^ 8'(i));
    $display("test transmit done");
    wr(`OFS_LINE_CTRL, 8'h1b);
    rxs(8'ha5, 1'b0, 1'b1);
    rc("lsr data", `OFS_LINE_STAT, 8'h1f, 8'h01);
    rc("rx hold", `OFS_HOLD, 8'hff, 8'ha5);
    rxs(8'h3c, 1'b1, 1'b1);
    rc("lsr parity", `OFS_LINE_STAT, 8'h1f, 8'h05);
    rc("rx hold", `OFS_HOLD, 8'hff, 8'h3c);
    rxs(8'h0f, 1'b0, 1'b0);
    rc("lsr frame", `OFS_LINE_STAT, 8'h1f, 8'h09);
    rc("rx hold", `OFS_HOLD, 8'hff, 8'h0f);
    rxs(8'h01, 1'b0, 1'b1);
    rxs(8'h02, 1'b0, 1'b1);
    rc("lsr overrun", `OFS_LINE_STAT, 8'h1f, 8'h03);
    rc("rx hold", `OFS_HOLD, 8'hff, 8'h02);
    peer_u.level(1'b0, 16 * 12);
    peer_u.level(1'b1, 200);
    rc("lsr break", `OFS_LINE_STAT, 8'h10, 8'h10);
    rc("rx hold", `OFS_HOLD, 8'h00, 8'h00);
    peer_u.level(1'b0, 4);
    peer_u.level(1'b1, 200);
    rc("false start", `OFS_LINE_STAT, 8'h01, 8'h00);
    $display("test receive done");
    wr(`OFS_INT_EN, 8'h02);
    tick(2);
    chk("irq tx", 8'h01, {7'h0, irq});
    rc("iid tx", `OFS_INT_ID, 8'hff, 8'h02);
    tick(2);
    chk("irq clear", 8'h00, {7'h0, irq});
    wr(`OFS_INT_EN, 8'h01);
    rxs(8'h77, 1'b0, 1'b1);
    tick(2);
    chk("irq rx", 8'h01, {7'h0, irq});
    rc("iid rx", `OFS_INT_ID, 8'hff, 8'h04);
    rc("rx hold", `OFS_HOLD, 8'hff, 8'h77);
    tick(2);
    chk("irq rx clear", 8'h00, {7'h0, irq});
    wr(`OFS_INT_EN, 8'h00);
    $display("test interrupt done");
    wr(`OFS_MODEM_CTRL, 8'h03);
    chk("modem out on", 8'h00, {6'h0, modem_out});
    peer_u.m_set(4'b0111);
    tick(4);
    rc("msr cts", `OFS_MODEM_STAT, 8'h11, 8'h11);
    rc("msr cts again", `OFS_MODEM_STAT, 8'h11, 8'h10);
    wr(`OFS_MODEM_CTRL, 8'h10);
    wr(`OFS_LINE_CTRL, 8'h03);
    wr(`OFS_HOLD, 8'hc3);
    wait_dr();
    chk("loop line idle", 8'h00, {7'h0, lb_bad});
    rc("loop data", `OFS_HOLD, 8'hff, 8'hc3);
    tick(32);
    wr(`OFS_MODEM_CTRL, 8'h00);
    chk("modem out off", 8'h03, {6'h0, modem_out});
    $display("test modem done");
    wr(`OFS_LINE_CTRL, 8'h83);
    wr(`OFS_HOLD, 8'h03);
    wr(`OFS_INT_EN, 8'h00);
    wr(`OFS_LINE_CTRL, 8'h03);
    per(8'd48);
    peer_u.bit_clks = 48;
    txc(8'h03, 8'hc5);
    $display("test divisor done");
    report_and_stop();
  end
endmodule
